/* File: src/ddr3_mode_defs.svh */
`ifndef DDR3_MODE_DEFS_SVH
`define DDR3_MODE_DEFS_SVH

// Bank address codes that select a mode register
`define BA_MR1          3'h1
`define BA_MR2          3'h2
`define BA_MR3          3'h3

// Mode register field positions
`define MR1_DLL_OFF     0
`define MR1_DRV_LO      1
`define MR1_RTT0        2
`define MR1_AL_LO       3
`define MR1_AL_HI       4
`define MR1_DRV_HI      5
`define MR1_RTT1        6
`define MR1_WLEV        7
`define MR1_RTT2        9
`define MR1_QOFF        12
`define MR2_PASR_LO     0
`define MR2_PASR_HI     2
`define MR2_CWL_LO      3
`define MR2_CWL_HI      5
`define MR2_RTTWR_LO    9
`define MR2_RTTWR_HI    10
`define MR3_LOC_LO      0
`define MR3_LOC_HI      1
`define MR3_MPR_EN      2

// Reset values of the mode registers
`define MR_RESET        15'h0000

// Offset of the lowest CAS write latency code
`define CWL_BASE        4'h5

// Calibration pattern, burst bit 0 in the LSB
`define MPR_PATTERN     8'haa

`endif

/* File: src/ddr3_mode_mpr.sv */
`timescale 1ns/10ps
`include "ddr3_mode_defs.svh"

// Functional notes
// - MRS with bank code one loads address pins into MR1.
// - MRS with bank code two loads address pins into MR2.
// - MRS with bank code three loads address pins into MR3.
// - Enabled DLL turns off in self-refresh and back on at exit.
// - Writes need no DLL unless write termination is enabled.
// - Driver impedance comes from MR1 bits A5 and A1.
// - Read or write accepted after activate, delayed by additive latency.
// - MR1 A4,A3 give additive latency 0, CL-1, CL-2, reserved.
// - CAS write latency in whole cycles from MR2 A5..A3.
// - Write latency AL plus CWL; read latency AL plus CL.
// - MR1 A12 set disconnects all data and strobe drivers.
// - Partial self-refresh may lose data outside the kept range.
// - Dynamic termination from MR2 A10,A9; off during write leveling.
// - MPR disabled: MR3 A1,A0 ignored, accesses go to the array.
// - MPR enabled: every read returns register content chosen by A1,A0; here a read taken before the last burst is queued is dropped.
// - In MPR mode a read with auto-precharge skips the precharge.
// - Location 00 returns pattern 0,1,0,1,0,1,0,1; others reserved.
// - MPR bit drives DQ0 of each lane; other bits copy it.
module ddr3_mode_mpr
    import ddr3_mode_pkg::*;
#(
    parameter int ADDR_W = 15,
    parameter int LAT_W  = 6,
    parameter int DEPTH  = 16
) (
    // Clock, reset and enable
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              en,
    // Command link, sampled on rising edges of the link clock
    input  wire logic              linkClk,
    input  wire logic              csN,
    input  wire logic              rasN,
    input  wire logic              casN,
    input  wire logic              weN,
    input  wire logic [2:0]        bankAddr,
    input  wire logic [ADDR_W-1:0] addr,
    // Device state and latency inputs
    input  wire logic              selfRefresh,
    input  wire logic [4:0]        casLatency,
    // Array read data and its request
    input  wire logic [15:0]       arrayData,
    output logic                   arrayRead,
    output logic                   arrayWrite,
    output logic                   autoPrecharge,
    // Read data stream towards the pins
    output logic                   dqValid,
    input  wire logic              dqReady,
    output logic [15:0]            dqOut,
    output logic                   dqOe,
    // Decoded configuration
    output logic                   dllOn,
    output logic [1:0]             drvSel,
    output logic [2:0]             rttNom,
    output logic [1:0]             rttWr,
    output logic [2:0]             pasr,
    output logic                   mprEn,
    output logic [LAT_W-1:0]       readLat,
    output logic [LAT_W-1:0]       writeLat,
    output logic                   fifoFull
);
    if (ADDR_W != 15 || LAT_W < 6) begin : g_bad_param
        $error("ddr3_mode_mpr: ADDR_W must be 15 and LAT_W >= 6");
    end

    // Additive latency from the MR1 code
    function automatic logic [LAT_W-1:0] alCycles(
        input logic [1:0] code,
        input logic [4:0] cl
    );
        unique case (al_mode_t'(code))
            AlClMinus1: alCycles = LAT_W'(cl) - LAT_W'(1);
            AlClMinus2: alCycles = LAT_W'(cl) - LAT_W'(2);
            default:    alCycles = '0;
        endcase
    endfunction

    // Three-stage synchronisers for every link input
    localparam int LW = 4 + 1 + 3 + ADDR_W;
    // Idle pins: deselected and link clock low, so no false edge at reset
    localparam logic [LW-1:0] SYNC_IDLE = {4'hf, 1'b0, {(3 + ADDR_W){1'b0}}};
    logic [LW-1:0] s1_q;
    logic [LW-1:0] s2_q;
    logic [LW-1:0] s3_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s1_q <= SYNC_IDLE;
            s2_q <= SYNC_IDLE;
            s3_q <= SYNC_IDLE;
        end else if (en) begin
            s1_q <= {csN, rasN, casN, weN, linkClk, bankAddr, addr};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Rising link edge: second and third stages agree on the new level
    logic              ckSeen_q;
    logic              linkRise;
    logic [3:0]        cmdPins;
    logic [2:0]        ba;
    logic [ADDR_W-1:0] a;
    assign cmdPins = s3_q[LW-1:LW-4];
    assign ba      = s3_q[ADDR_W+2:ADDR_W];
    assign a       = s3_q[ADDR_W-1:0];
    assign linkRise = s2_q[LW-5] && s3_q[LW-5] && !ckSeen_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ckSeen_q <= 1'b0;
        end else if (en && (s2_q[LW-5] == s3_q[LW-5])) begin
            ckSeen_q <= s3_q[LW-5];
        end
    end

    // Command decode on the link edge
    cmd_t cmd;
    always_comb begin
        cmd = CmdNop;
        if (linkRise && !cmdPins[3]) begin
            unique case (cmdPins[2:0])
                3'h0:    cmd = CmdMrs;
                3'h5:    cmd = CmdRead;
                3'h4:    cmd = CmdWrite;
                3'h7:    cmd = CmdNop;
                default: cmd = CmdOther;
            endcase
        end
    end

    // Mode registers, held until their own MRS overwrites them
    logic [ADDR_W-1:0] mr1_q;
    logic [ADDR_W-1:0] mr2_q;
    logic [ADDR_W-1:0] mr3_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mr1_q <= `MR_RESET;
            mr2_q <= `MR_RESET;
            mr3_q <= `MR_RESET;
        end else if (en && cmd == CmdMrs) begin
            if (ba == `BA_MR1) mr1_q <= a;
            if (ba == `BA_MR2) mr2_q <= a;
            if (ba == `BA_MR3) mr3_q <= a;
        end
    end

    // Field decode
    logic             mpr;
    logic             wlev;
    logic [LAT_W-1:0] al;
    logic [LAT_W-1:0] cwl;
    assign mpr  = mr3_q[`MR3_MPR_EN];
    assign wlev = mr1_q[`MR1_WLEV];
    assign al   = alCycles(mr1_q[`MR1_AL_HI:`MR1_AL_LO], casLatency);
    assign cwl  = LAT_W'(mr2_q[`MR2_CWL_HI:`MR2_CWL_LO])
                + LAT_W'(`CWL_BASE);

    // Configuration outputs, registered
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dllOn    <= 1'b0;
            drvSel   <= 2'h0;
            rttNom   <= 3'h0;
            rttWr    <= 2'h0;
            pasr     <= 3'h0;
            mprEn    <= 1'b0;
            readLat  <= '0;
            writeLat <= '0;
        end else if (en) begin
            // DLL follows MR1 but drops out during self-refresh
            dllOn  <= !mr1_q[`MR1_DLL_OFF] && !selfRefresh;
            drvSel <= {mr1_q[`MR1_DRV_HI], mr1_q[`MR1_DRV_LO]};
            rttNom <= {mr1_q[`MR1_RTT2], mr1_q[`MR1_RTT1],
                       mr1_q[`MR1_RTT0]};
            rttWr  <= wlev ? 2'h0 :
                      mr2_q[`MR2_RTTWR_HI:`MR2_RTTWR_LO];
            pasr   <= mr2_q[`MR2_PASR_HI:`MR2_PASR_LO];
            mprEn  <= mpr;
            readLat  <= al + LAT_W'(casLatency);
            writeLat <= al + cwl;
        end
    end

    // Array strobes: delay by AL, MPR reads never reach the array
    logic [LAT_W-1:0] alCnt_q;
    logic             pendRd_q;
    logic             pendWr_q;
    logic             pendAp_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            alCnt_q  <= '0;
            pendRd_q <= 1'b0;
            pendWr_q <= 1'b0;
            pendAp_q <= 1'b0;
        end else if (en) begin
            if ((cmd == CmdRead && !mpr) || cmd == CmdWrite) begin
                alCnt_q  <= al;
                pendRd_q <= (cmd == CmdRead);
                pendWr_q <= (cmd == CmdWrite);
                pendAp_q <= a[10];
            end else if (alCnt_q != '0) begin
                alCnt_q <= alCnt_q - 1'b1;
            end else begin
                pendRd_q <= 1'b0;
                pendWr_q <= 1'b0;
            end
        end
    end

    // One-cycle internal command pulses once AL has run out
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            arrayRead     <= 1'b0;
            arrayWrite    <= 1'b0;
            autoPrecharge <= 1'b0;
        end else if (en) begin
            arrayRead     <= pendRd_q && alCnt_q == '0;
            arrayWrite    <= pendWr_q && alCnt_q == '0;
            autoPrecharge <= (pendRd_q || pendWr_q) && alCnt_q == '0
                             && pendAp_q;
        end
    end

    // MPR burst: pattern for location 00, zero for reserved codes
    rd_state_t        rd_q;
    logic [LAT_W-1:0] rdCnt_q;
    logic [3:0]       beat_q;
    logic [2:0]       beatStart_q;
    logic [7:0]       mprWord;
    logic             fifoInReady;
    logic             fifoPush;
    logic [15:0]      fifoIn;
    assign mprWord = (mr3_q[`MR3_LOC_HI:`MR3_LOC_LO] == 2'h0) ?
                     `MPR_PATTERN : 8'h00;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_q        <= RdIdle;
            rdCnt_q     <= '0;
            beat_q      <= 4'h0;
            beatStart_q <= 3'h0;
        end else if (en) begin
            unique case (rd_q)
                RdIdle: begin
                    // RDA behaves as a plain read here; a read taken
                    // before the last burst is queued is not served
                    if (cmd == CmdRead && mpr) begin
                        rd_q        <= RdWait;
                        rdCnt_q     <= al + LAT_W'(casLatency);
                        beatStart_q <= {a[2], 2'h0};
                        beat_q      <= a[12] ? 4'h8 : 4'h4;
                    end
                end
                RdWait: begin
                    if (rdCnt_q == '0) begin
                        rd_q <= RdBurst;
                    end else begin
                        rdCnt_q <= rdCnt_q - 1'b1;
                    end
                end
                RdBurst: begin
                    if (fifoInReady) begin
                        beatStart_q <= beatStart_q + 3'h1;
                        beat_q      <= beat_q - 4'h1;
                        if (beat_q == 4'h1) rd_q <= RdIdle;
                    end
                end
            endcase
        end
    end

    // Beat value replicated on every DQ of both lanes
    assign fifoPush = (rd_q == RdBurst);
    assign fifoIn   = {16{mprWord[beatStart_q]}};

    // Array data also uses the stream while the MPR is off
    logic        arrValid_q;
    logic        qValid;
    logic [15:0] qData;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            arrValid_q <= 1'b0;
        end else if (en) begin
            arrValid_q <= arrayRead;
        end
    end

    sync_fifo #(
        .WIDTH (16),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk      (clk),
        .nrst     (nrst),
        .en       (en),
        .inValid  (fifoPush || arrValid_q),
        .inReady  (fifoInReady),
        .inData   (fifoPush ? fifoIn : arrayData),
        .outValid (qValid),
        .outReady (!dqValid || dqReady), // Pop as the output takes it
        .outData  (qData)
    );

    // Output stage: drivers cut off entirely when Qoff is set
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dqValid  <= 1'b0;
            dqOut    <= 16'h0000;
            dqOe     <= 1'b0;
            fifoFull <= 1'b0;
        end else if (en) begin
            fifoFull <= !fifoInReady;
            if (!dqValid || dqReady) begin
                dqValid <= qValid;
                if (qValid) begin
                    dqOut <= qData;
                end
            end
            dqOe <= qValid && !mr1_q[`MR1_QOFF];
        end
    end
endmodule // ddr3_mode_mpr

/* File: src/ddr3_mode_pkg.sv */
package ddr3_mode_pkg;
    // Decoded command on the command bus
    typedef enum logic [2:0] {
        CmdNop,
        CmdMrs,
        CmdRead,
        CmdWrite,
        CmdOther
    } cmd_t;

    // Additive latency setting
    typedef enum logic [1:0] {
        AlZero,
        AlClMinus1,
        AlClMinus2,
        AlReserved
    } al_mode_t;

    // Read burst state
    typedef enum logic [1:0] {
        RdIdle,
        RdWait,
        RdBurst
    } rd_state_t;
endpackage

/* File: src/sync_fifo.sv */
`timescale 1ns/10ps
// Small synchronous FIFO with valid/ready on both sides
module sync_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             en,
    // Fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("sync_fifo: DEPTH must be a power of two >= 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wrPtr_q;
    logic [AW:0]      rdPtr_q;
    logic [AW:0]      rdNext;
    logic             push;
    logic             pop;
    logic             full;
    logic             empty;

    // Honest full and empty from the extra pointer bit
    assign full  = (wrPtr_q[AW] != rdPtr_q[AW]) &&
                   (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]);
    assign empty = (wrPtr_q == rdPtr_q);
    assign push  = en && inValid && !full;
    assign pop   = en && outReady && !empty;
    assign inReady = !full;
    assign rdNext  = rdPtr_q + (AW+1)'(pop);

    // Storage; head word read into a register, a fresh write bypassed
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr_q[AW-1:0]] <= inData;
        end
        if (en) begin
            if (push && wrPtr_q[AW-1:0] == rdNext[AW-1:0]) begin
                outData <= inData;
            end else begin
                outData <= mem[rdNext[AW-1:0]];
            end
        end
    end

    // Pointers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
        end else begin
            if (push) begin
                wrPtr_q <= wrPtr_q + 1'b1;
            end
            if (pop) begin
                rdPtr_q <= rdPtr_q + 1'b1;
            end
        end
    end

    // Head of the queue is valid whenever the store is not empty
    assign outValid = !empty;
endmodule // sync_fifo

/* File: tb/ddr3_ctrl_model.sv */
`timescale 1ns/10ps
// Controller side: one command per link clock pulse
module ddr3_ctrl_model (
    // Clock
    input wire logic    clk,
    // Command link
    output logic        linkClk,
    output logic        csN,
    output logic        rasN,
    output logic        casN,
    output logic        weN,
    output logic [2:0]  bankAddr,
    output logic [14:0] addr
);
    // Deselected, link clock still
    initial begin
        linkClk = 1'b0;
        {csN, rasN, casN, weN} = 4'hf;
        bankAddr = 3'h0;
        addr = 15'h0;
    end

    // Pins stand around the rise, then are released: deselect, bank and address inverted
    task automatic send(input logic [3:0] cmd, input logic [2:0] ba,
                        input logic [14:0] a);
        @(posedge clk);
        #1;
        {csN, rasN, casN, weN} = cmd;
        bankAddr = ba;
        addr = (cmd == 4'h0 && ba == 3'h1) ? a & 15'h12ff : a;
        #62.5 linkClk = 1'b1;
        #62.5 linkClk = 1'b0;
        @(posedge clk);
        #1;
        {csN, rasN, casN, weN} = 4'hf;
        bankAddr = ~ba;
        addr = ~a;
    endtask
endmodule // ddr3_ctrl_model

/* File: tb/ddr3_mode_mpr_checker.sv */
`timescale 1ns/10ps
`include "ddr3_mode_defs.svh"
// Captures each command at the link clock and checks the outputs
module ddr3_mode_mpr_checker #(
    parameter int ADDR_W = 15
) (
    // Clock and reset
    input wire logic              clk,
    input wire logic              nrst,
    // Command link
    input wire logic              linkClk,
    input wire logic              csN,
    input wire logic              rasN,
    input wire logic              casN,
    input wire logic              weN,
    input wire logic [2:0]        bankAddr,
    input wire logic [ADDR_W-1:0] addr,
    // Device side
    input wire logic              selfRefresh,
    input wire logic              arrayRead,
    input wire logic              autoPrecharge,
    input wire logic              dqOe,
    input wire logic              dllOn,
    input wire logic [1:0]        drvSel,
    input wire logic [2:0]        rttNom,
    input wire logic [2:0]        pasr,
    input wire logic              mprEn
);
    logic              linkA_q;
    logic              linkB_q;
    logic              mrs_q;
    logic [2:0]        bank_q;
    logic [ADDR_W-1:0] adr_q;
    logic [3:0]        age_q;
    logic              qoff_q;
    logic              mr1;
    logic              mr2;
    logic              mr3;

    // Register selected by the last captured command
    assign mr1 = mrs_q && bank_q == `BA_MR1;
    assign mr2 = mrs_q && bank_q == `BA_MR2;
    assign mr3 = mrs_q && bank_q == `BA_MR3;

    // Link clock edge finder; age counts cycles since the last rise
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            linkA_q <= 1'b0;
            linkB_q <= 1'b0;
            mrs_q   <= 1'b0;
            bank_q  <= 3'h0;
            adr_q   <= '0;
            age_q   <= 4'hf;
        end else begin
            linkA_q <= linkClk;
            linkB_q <= linkA_q;
            if (linkA_q && !linkB_q) begin
                mrs_q  <= !(csN || rasN || casN || weN);
                bank_q <= bankAddr;
                adr_q  <= addr;
                age_q  <= 4'h0;
            end else if (age_q != 4'hf) begin
                age_q <= age_q + 4'h1;
            end
        end
    end

    // Output disable bit as last written, in step with the output register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            qoff_q <= 1'b0;
        end else if (mr1 && age_q == 4'h2) begin
            qoff_q <= adr_q[`MR1_QOFF];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    AST_MR1_LOAD: assert property (mr1 && age_q == 4'ha |->
        drvSel == {adr_q[5], adr_q[1]} &&
        rttNom == {adr_q[9], adr_q[6], adr_q[2]})
        else $error("MR1 fields not loaded");
    AST_MR2_LOAD: assert property (mr2 && age_q == 4'ha |->
        pasr == adr_q[2:0]) else $error("MR2 not loaded");
    AST_MR3_LOAD: assert property (mr3 && age_q == 4'ha |->
        mprEn == adr_q[2]) else $error("MR3 not loaded");
    AST_DRV_HOLD: assert property ($changed(drvSel) |->
        mr1 && age_q <= 4'ha) else $error("drive setting changed alone");
    AST_MPR_NO_ARRAY: assert property (mprEn |-> !arrayRead)
        else $error("array read in MPR mode");
    AST_MPR_NO_AP: assert property (mprEn |-> !autoPrecharge)
        else $error("precharge in MPR mode");
    AST_QOFF: assert property (qoff_q |-> !dqOe)
        else $error("drivers on while disabled");
    AST_DLL_SR: assert property (selfRefresh [*4] |-> !dllOn)
        else $error("DLL on in self-refresh");
    COV_MPR: cover property ($rose(mprEn));
    COV_SR: cover property (selfRefresh [*4]);
    COV_READ: cover property (arrayRead);
endmodule // ddr3_mode_mpr_checker

bind ddr3_mode_mpr ddr3_mode_mpr_checker #(.ADDR_W(ADDR_W)) i_checker (
    .clk(clk), .nrst(nrst), .linkClk(linkClk), .csN(csN), .rasN(rasN),
    .casN(casN), .weN(weN), .bankAddr(bankAddr), .addr(addr),
    .selfRefresh(selfRefresh), .arrayRead(arrayRead),
    .autoPrecharge(autoPrecharge), .dqOe(dqOe), .dllOn(dllOn),
    .drvSel(drvSel), .rttNom(rttNom), .pasr(pasr), .mprEn(mprEn));

/* File: tb/testbench.sv */
`timescale 1ns/10ps
// Command sequences with expected outputs
module testbench;
    import ddr3_mode_pkg::*;
    localparam int CL = 9;
    logic        clk, nrst, en, selfRefresh, dqReady, linkClk;
    logic        csN, rasN, casN, weN, arrayRead, arrayWrite;
    logic        autoPrecharge, dqValid, dqOe, dllOn, mprEn, fifoFull;
    logic [2:0]  bankAddr, rttNom, pasr;
    logic [14:0] addr;
    logic [4:0]  casLatency;
    logic [15:0] arrayData, dqOut;
    logic [1:0]  drvSel, rttWr, c;
    logic [5:0]  readLat, writeLat;
    int          mismatches = 0;
    int          nCompared = 0;
    int          nRd = 0;
    int          nWr = 0;
    int          nAp = 0;
    int          al;

    ddr3_ctrl_model i_ddr3_ctrl_model (.*);
    ddr3_mode_mpr i_ddr3_mode_mpr (.*);

    // Clock
    initial clk = 1'b0;
    always #5 clk = ~clk;

    // Count array strobes
    always @(posedge clk) begin
        nRd += int'(arrayRead === 1'b1);
        nWr += int'(arrayWrite === 1'b1);
        nAp += int'(autoPrecharge === 1'b1);
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        nCompared++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("compared %0d, mismatches %0d", nCompared, mismatches);
        if (mismatches == 0 && nCompared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic mrs(input logic [2:0] ba, input logic [14:0] a);
        i_ddr3_ctrl_model.send(4'h0, ba, a);
        tick(4);
    endtask

    // Take n beats; the calibration pattern alternates 0,1 from bit 0
    task automatic drain(input int n);
        int got;
        got = 0;
        dqReady = 1'b1;
        for (int k = 0; k < 100 && got < n; k++) begin
            @(negedge clk);
            if (dqValid === 1'b1) begin
                check(dqOut, {16{got[0]}});
                got++;
            end
        end
        tick(1);
        dqReady = 1'b0;
        check(got, n);
        if (got < n) begin
            stop_test();
        end
    endtask

    initial begin
        nrst = 1'b0;
        en = 1'b1;
        selfRefresh = 1'b0;
        dqReady = 1'b0;
        casLatency = 5'(CL);
        arrayData = 16'h5a3c;
        tick(10);
        nrst = 1'b1;
        tick(3);
        check(dllOn, 1'b1);
        check({drvSel, rttNom, rttWr, pasr, mprEn}, 16'h0);
        check(readLat, 6'(CL));
        check(writeLat, 6'h05);
        $display("test reset done");
        // Every additive latency code with drive and termination settings
        for (int j = 0; j < 4; j++) begin
            c = j[1:0];
            al = (c == 2'h1) ? CL - 1 : (c == 2'h2) ? CL - 2 : 0;
            mrs(3'h1, {5'h0, 1'b1, 2'h0, c[1], c[1], c, c[0], c[0], 1'b0});
            check(drvSel, c);
            check(rttNom, {1'b1, c});
            check(readLat, 6'(al + CL));
            check(writeLat, 6'(al + 5));
        end
        $display("test mr1 done");
        mrs(3'h1, 15'h0008);
        mrs(3'h2, 15'h041d);
        check(writeLat, 6'(CL - 1 + 8));
        check(rttWr, 2'h2);
        check(pasr, 3'h5);
        check(readLat, 6'(2 * CL - 1));
        mrs(3'h1, 15'h008c);
        check(rttWr, 2'h0);
        mrs(3'h1, 15'h0008);
        check(rttWr, 2'h2);
        $display("test mr2 done");
        // Termination off before the DLL goes off
        mrs(3'h2, 15'h001d);
        mrs(3'h1, 15'h0009);
        check(dllOn, 1'b0);
        mrs(3'h1, 15'h0008);
        check(dllOn, 1'b1);
        selfRefresh = 1'b1;
        tick(6);
        check(dllOn, 1'b0);
        selfRefresh = 1'b0;
        tick(6);
        check(dllOn, 1'b1);
        $display("test dll done");
        // Activate, then read with auto-precharge held for AL
        i_ddr3_ctrl_model.send(4'h3, 3'h0, 15'h0010);
        i_ddr3_ctrl_model.send(4'h5, 3'h0, 15'h0400);
        check(nRd, 0);
        tick(20);
        check(nRd, 1);
        check(nAp, 1);
        i_ddr3_ctrl_model.send(4'h4, 3'h0, 15'h0000);
        tick(20);
        check(nWr, 1);
        check(dqValid, 1'b1);
        check(dqOut, 16'h5a3c);
        dqReady = 1'b1;
        tick(40);
        dqReady = 1'b0;
        $display("test array done");
        // Precharge all before entering MPR; only reads while in it
        i_ddr3_ctrl_model.send(4'h2, 3'h0, 15'h0400);
        tick(5);
        mrs(3'h3, 15'h0004);
        check(mprEn, 1'b1);
        // Two BL8 bursts then a chop: 20 beats, one waits in the output
        i_ddr3_ctrl_model.send(4'h5, 3'h0, 15'h1400);
        tick(25);
        i_ddr3_ctrl_model.send(4'h5, 3'h0, 15'h1400);
        tick(25);
        i_ddr3_ctrl_model.send(4'h5, 3'h0, 15'h0400);
        tick(40);
        check(fifoFull, 1'b1);
        check(dqOe, 1'b1);
        check(nRd, 1);
        check(nAp, 1);
        drain(20);
        mrs(3'h3, 15'h0001);
        check(mprEn, 1'b0);
        i_ddr3_ctrl_model.send(4'h5, 3'h0, 15'h0000);
        tick(20);
        check(nRd, 2);
        dqReady = 1'b1;
        tick(40);
        dqReady = 1'b0;
        $display("test mpr done");
        // Outputs disabled, upper nibble chop read
        mrs(3'h1, 15'h1008);
        mrs(3'h3, 15'h0004);
        i_ddr3_ctrl_model.send(4'h5, 3'h0, 15'h0004);
        tick(30);
        check(dqOe, 1'b0);
        drain(4);
        mrs(3'h3, 15'h0000);
        $display("test qoff done");
        stop_test();
    end
endmodule // testbench
